// ### rtl/alu_pkg.sv
// Behaviour
// - Add and add-with-carry store the sum, set Z C N V H, one clock.
// - Word add of a constant to a register pair, sets Z C N V S, two clocks.
// - Subtract register or constant stores the difference, sets Z C N V H, one clock.
// - Subtract-with-carry also deducts the carry flag, sets Z C N V H, one clock.
// - Word subtract of a constant from a register pair, sets Z C N V S, two clocks.
// - AND with register or constant stores the result, sets only Z N V, one clock.
// - OR with register or constant stores the result, sets only Z N V, one clock.
// - Test ANDs a register with itself, keeps it, sets Z N V, one clock.
// - Increment adds one, sets Z N V, leaves carry alone, one clock.
package alu_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_DEST = 32'h0000_0000;
  localparam logic [31:0] OFF_SRC = 32'h0000_0004;
  localparam logic [31:0] OFF_IMM = 32'h0000_0008;
  localparam logic [31:0] OFF_PAIR_HI = 32'h0000_000c;
  localparam logic [31:0] OFF_CMD = 32'h0000_0010;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_0014;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0018;

  // ----------------------------------------------------------------
  // Flag positions, masks and constants
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] MASK_ARITH = 6'h2f;
  localparam logic [5:0] MASK_WORD = 6'h1f;
  localparam logic [5:0] MASK_LOGIC = 6'h0e;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] INC_STEP = 8'h01;
  localparam logic [7:0] INC_OVF_VALUE = 8'h80;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    add_op = 4'h0,
    add_carry_op = 4'h1,
    subtract_op = 4'h2,
    subtract_immediate_op = 4'h3,
    subtract_with_carry_op = 4'h4,
    subtract_carry_immediate_op = 4'h5,
    and_op = 4'h6,
    and_immediate_op = 4'h7,
    or_op = 4'h8,
    or_immediate_op = 4'h9,
    test_value_op = 4'ha,
    increment_op = 4'hb,
    word_add_immediate_op = 4'hc,
    word_subtract_immediate_op = 4'hd
  } op_t;

  typedef enum logic [2:0] {
    k_add = 3'b000,
    k_sub = 3'b001,
    k_and = 3'b010,
    k_or = 3'b011,
    k_inc = 3'b100
  } kind_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_low = 2'b01,
    st_high = 2'b10
  } st_t;

endpackage : alu_pkg

// ### rtl/alu_if.sv
`timescale 1ns/10ps
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  alu_pkg::kind_t kind;
  logic [7:0] r;
  logic c;
  logic h;
  logic v;
  modport core (input a, input b, input cin, input kind, output r, output c, output h, output v);
  modport ctrl (output a, output b, output cin, output kind, input r, input c, input h, input v);
endinterface : alu_if

// ### rtl/alu_core.sv
`timescale 1ns/10ps
module alu_core import alu_pkg::*; (
  // Operand and result bundle
  alu_if.core io
);

  logic [8:0] wide;

  // ----------------------------------------------------------------
  // Byte-wide result and carry, half-carry, overflow
  // ----------------------------------------------------------------
  always_comb begin
    wide = 9'h000;
    io.r = BYTE_ZERO;
    io.c = 1'b0;
    io.h = 1'b0;
    io.v = 1'b0;
    case (io.kind)
      k_add: begin
        wide = {1'b0, io.a} + {1'b0, io.b} + {8'h00, io.cin};
        io.r = wide[7:0];
        io.c = wide[8];
        io.h = (io.a[3] & io.b[3]) | (io.b[3] & ~io.r[3]) | (~io.r[3] & io.a[3]);
        io.v = (io.a[7] & io.b[7] & ~io.r[7]) | (~io.a[7] & ~io.b[7] & io.r[7]);
      end
      k_sub: begin
        wide = {1'b0, io.a} - {1'b0, io.b} - {8'h00, io.cin};
        io.r = wide[7:0];
        io.c = wide[8];
        io.h = (~io.a[3] & io.b[3]) | (io.b[3] & io.r[3]) | (io.r[3] & ~io.a[3]);
        io.v = (io.a[7] & ~io.b[7] & ~io.r[7]) | (~io.a[7] & io.b[7] & io.r[7]);
      end
      k_and: begin
        io.r = io.a & io.b;
      end
      k_or: begin
        io.r = io.a | io.b;
      end
      k_inc: begin
        wide = {1'b0, io.a} + {1'b0, INC_STEP};
        io.r = wide[7:0];
        io.v = (io.r == INC_OVF_VALUE);
      end
      default: begin
        io.r = BYTE_ZERO;
      end
    endcase
  end

endmodule : alu_core

// ### rtl/arith_logic_unit.sv
`timescale 1ns/10ps
module arith_logic_unit import alu_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 5 and 32");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [31:0] off);
    return addr == off[ADDR_W-1:0];
  endfunction : hit
  function automatic logic is_word(input op_t op);
    return op == word_add_immediate_op || op == word_subtract_immediate_op;
  endfunction : is_word
  function automatic logic uses_imm(input op_t op);
    return op == subtract_immediate_op || op == subtract_carry_immediate_op ||
           op == and_immediate_op || op == or_immediate_op || is_word(op);
  endfunction : uses_imm
  function automatic logic uses_carry(input op_t op);
    return op == add_carry_op || op == subtract_with_carry_op ||
           op == subtract_carry_immediate_op;
  endfunction : uses_carry
  function automatic logic op_legal(input logic [3:0] code);
    return code <= word_subtract_immediate_op;
  endfunction : op_legal
  function automatic kind_t op_kind(input op_t op);
    case (op)
      add_op, add_carry_op, word_add_immediate_op: return k_add;
      and_op, and_immediate_op, test_value_op: return k_and;
      or_op, or_immediate_op: return k_or;
      increment_op: return k_inc;
      default: return k_sub;
    endcase
  endfunction : op_kind
  function automatic logic [5:0] op_mask(input op_t op);
    case (op)
      and_op, and_immediate_op, or_op, or_immediate_op, test_value_op, increment_op:
        return MASK_LOGIC;
      word_add_immediate_op, word_subtract_immediate_op: return MASK_WORD;
      default: return MASK_ARITH;
    endcase
  endfunction : op_mask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  alu_if alu ();
  st_t state_reg;
  op_t op_reg;
  logic [7:0] dest_reg;
  logic [7:0] source_register_reg;
  logic [7:0] imm_reg;
  logic [7:0] pair_hi_reg;
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic [5:0] fresh;
  logic word_carry_reg;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  logic rd_ready_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] rd_value;
  logic busy;
  logic bus_wr;
  logic op_start;
  logic commit;

  alu_core u_core (
    .io(alu)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign busy = (state_reg != st_idle);
  assign bus_wr = dp_valid_reg && dp_write_reg && !busy;
  assign op_start = bus_wr && hit(dp_addr_reg, OFF_CMD) && op_legal(hwdata[3:0]);
  assign hreadyout = dp_valid_reg ? (dp_write_reg ? !busy : rd_ready_reg) : 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else if (hready) begin
      dp_valid_reg <= hsel && htrans[1];
      dp_write_reg <= hwrite;
      dp_addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  always_comb begin
    rd_value = BYTE_ZERO;
    if (hit(dp_addr_reg, OFF_DEST)) begin
      rd_value = dest_reg;
    end else if (hit(dp_addr_reg, OFF_SRC)) begin
      rd_value = source_register_reg;
    end else if (hit(dp_addr_reg, OFF_IMM)) begin
      rd_value = imm_reg;
    end else if (hit(dp_addr_reg, OFF_PAIR_HI)) begin
      rd_value = pair_hi_reg;
    end else if (hit(dp_addr_reg, OFF_CMD)) begin
      rd_value = {4'h0, op_reg};
    end else if (hit(dp_addr_reg, OFF_FLAGS)) begin
      rd_value = {2'b00, flags_reg};
    end else if (hit(dp_addr_reg, OFF_STATUS)) begin
      rd_value = {7'h00, busy};
    end
  end

  // Reads take one wait state once the sequencer is idle, so that read data leave a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ready_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else if (dp_valid_reg && !dp_write_reg && !busy && !rd_ready_reg) begin
      rd_ready_reg <= 1'b1;
      hrdata_reg <= {24'h00_0000, rd_value};
    end else begin
      rd_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_register_reg <= BYTE_ZERO;
      imm_reg <= BYTE_ZERO;
    end else if (bus_wr && hit(dp_addr_reg, OFF_SRC)) begin
      source_register_reg <= hwdata[7:0];
    end else if (bus_wr && hit(dp_addr_reg, OFF_IMM)) begin
      imm_reg <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: one pass for byte ops, low then high pass for words
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= st_idle;
      op_reg <= add_op;
    end else begin
      case (state_reg)
        st_idle: begin
          if (op_start) begin
            state_reg <= st_low;
            op_reg <= op_t'(hwdata[3:0]);
          end
        end
        st_low: begin
          state_reg <= is_word(op_reg) ? st_high : st_idle;
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  always_comb begin
    alu.kind = op_kind(op_reg);
    alu.a = dest_reg;
    alu.cin = 1'b0;
    if (uses_imm(op_reg)) begin
      alu.b = imm_reg;
    end else if (op_reg == test_value_op) begin
      alu.b = dest_reg;
    end else begin
      alu.b = source_register_reg;
    end
    if (state_reg == st_high) begin
      alu.a = pair_hi_reg;
      alu.b = BYTE_ZERO;
      alu.cin = word_carry_reg;
    end else if (uses_carry(op_reg)) begin
      alu.cin = flags_reg[FLAG_C];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_carry_reg <= 1'b0;
    end else if (state_reg == st_low) begin
      word_carry_reg <= alu.c;
    end
  end

  // ----------------------------------------------------------------
  // Results and flags
  // ----------------------------------------------------------------
  assign commit = (state_reg == st_low && !is_word(op_reg)) || state_reg == st_high;

  always_comb begin
    fresh = FLAGS_RESET;
    fresh[FLAG_C] = alu.c;
    fresh[FLAG_Z] = (alu.r == BYTE_ZERO) && (state_reg != st_high || dest_reg == BYTE_ZERO);
    fresh[FLAG_N] = alu.r[7];
    fresh[FLAG_V] = alu.v;
    fresh[FLAG_S] = alu.r[7] ^ alu.v;
    fresh[FLAG_H] = alu.h;
    flags_next = (fresh & op_mask(op_reg)) | (flags_reg & ~op_mask(op_reg));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= FLAGS_RESET;
    end else if (commit) begin
      flags_reg <= flags_next;
    end else if (bus_wr && hit(dp_addr_reg, OFF_FLAGS)) begin
      flags_reg <= hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dest_reg <= BYTE_ZERO;
    end else if (state_reg == st_low && op_reg != test_value_op) begin
      dest_reg <= alu.r;
    end else if (bus_wr && hit(dp_addr_reg, OFF_DEST)) begin
      dest_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair_hi_reg <= BYTE_ZERO;
    end else if (state_reg == st_high) begin
      pair_hi_reg <= alu.r;
    end else if (bus_wr && hit(dp_addr_reg, OFF_PAIR_HI)) begin
      pair_hi_reg <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] pair_w;
  assign pair_w = {pair_hi_reg, dest_reg};

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_add_sum: assert property ((state_reg == st_low && op_reg == add_op) |=>
    dest_reg == $past(dest_reg) + $past(source_register_reg) && !busy)
    else $error("add result or timing wrong");
  a_word_add_time: assert property ((op_start && hwdata[3:0] == word_add_immediate_op)
    |=> state_reg == st_low ##1 state_reg == st_high ##1 state_reg == st_idle)
    else $error("word add does not take two clocks");
  a_sub_imm_diff: assert property (
    (state_reg == st_low && op_reg == subtract_immediate_op) |=>
    dest_reg == $past(dest_reg) - $past(imm_reg)) else $error("subtract immediate result wrong");
  a_sbc_borrow: assert property (
    (state_reg == st_low && op_reg == subtract_with_carry_op) |=> dest_reg ==
    $past(dest_reg) - $past(source_register_reg) - {7'h00, $past(flags_reg[FLAG_C])})
    else $error("subtract with carry result wrong");
  a_word_sub_pair: assert property (
    (state_reg == st_low && op_reg == word_subtract_immediate_op) |=> ##1
    pair_w == $past(pair_w, 2) - {8'h00, $past(imm_reg, 2)})
    else $error("word subtract result wrong");
  a_and_flags_kept: assert property (
    (state_reg == st_low && op_reg == and_immediate_op) |=> !flags_reg[FLAG_V] &&
    $stable(flags_reg[FLAG_C]) && $stable(flags_reg[FLAG_H]) && $stable(flags_reg[FLAG_S]))
    else $error("AND touched a flag it must keep");
  a_or_result: assert property ((state_reg == st_low && op_reg == or_op) |=>
    dest_reg == ($past(dest_reg) | $past(source_register_reg)) && !flags_reg[FLAG_V])
    else $error("OR result wrong");
  a_test_keeps: assert property ((state_reg == st_low && op_reg == test_value_op) |=>
    $stable(dest_reg) && flags_reg[FLAG_Z] == (dest_reg == BYTE_ZERO))
    else $error("test changed the register or Z wrong");
  a_inc_carry_kept: assert property ((state_reg == st_low && op_reg == increment_op) |=>
    $stable(flags_reg[FLAG_C]) && dest_reg == $past(dest_reg) + INC_STEP)
    else $error("increment wrong or carry touched");
  a_zero_negative: assert property ((state_reg == st_low && !is_word(op_reg)) |=>
    flags_reg[FLAG_Z] == (dest_reg == BYTE_ZERO) && flags_reg[FLAG_N] == dest_reg[7])
    else $error("Z or N does not follow the result");
  a_sign_xor: assert property ((commit && is_word(op_reg)) |=>
    flags_reg[FLAG_S] == (flags_reg[FLAG_N] ^ flags_reg[FLAG_V]))
    else $error("S is not N xor V");

  c_word_add: cover property (state_reg == st_high && op_reg == word_add_immediate_op);
  c_add_carry: cover property (state_reg == st_low && op_reg == add_carry_op && alu.c);
  c_write_stall: cover property (dp_valid_reg && dp_write_reg && busy);
  c_read_back: cover property (rd_ready_reg && hit(dp_addr_reg, OFF_FLAGS));

endmodule : arith_logic_unit

// ### test/ahb_host.sv
`timescale 1ns/10ps
module ahb_host (
  // Clock
  input wire logic hclk,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Bus cycles, entered just after a rising edge
  // ----------------------------------------------------------------
  // The rising edge that samples ready high ends the phase; read data are taken there
  task automatic wait_ready(output logic [31:0] data);
    do @(posedge hclk); while (hready !== 1'b1);
    data = hrdata;
  endtask : wait_ready

  task automatic start(input logic [31:0] addr, input logic wr);
    logic [31:0] dummy;
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    // Stale write data is scrambled outside its data phase
    hwdata <= ~hwdata;
    wait_ready(dummy);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask : start

  task automatic write_reg(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    start(addr, 1'b1);
    hwdata <= data;
    wait_ready(dummy);
  endtask : write_reg

  task automatic read_reg(input logic [31:0] addr, output logic [31:0] data);
    start(addr, 1'b0);
    wait_ready(data);
  endtask : read_reg
endmodule : ahb_host

// ### test/arith_logic_unit_tb.sv
`timescale 1ns/10ps
module arith_logic_unit_tb import alu_pkg::*;;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int failures;
  int total_checks;
  int cycles;
  int seed;

  arith_logic_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  ahb_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Reference model: returns {flags, pair high, dest}
  // ----------------------------------------------------------------
  function automatic logic [21:0] model(input logic [3:0] op, input logic [7:0] d,
    input logic [7:0] s, input logic [7:0] k, input logic [7:0] hi, input logic [5:0] fl);
    logic [8:0] r9;
    logic [16:0] w;
    logic [7:0] x;
    logic [7:0] r;
    logic [7:0] rh;
    logic [5:0] m;
    logic [5:0] nf;
    logic c, h, v, cin, n, z;
    x = (op >= 4'h2 && op <= 4'h9 && op[0]) ? k : s;
    cin = (op == 4'h1 || op == 4'h4 || op == 4'h5) ? fl[0] : 1'b0;
    c = fl[0];
    h = fl[5];
    v = 1'b0;
    m = MASK_LOGIC;
    r = d;
    rh = hi;
    w = {1'b0, hi, d};
    case (op)
      4'h0, 4'h1: begin
        r9 = {1'b0, d} + {1'b0, x} + {8'h00, cin};
        c = r9[8];
        h = (int'(d[3:0]) + int'(x[3:0]) + int'(cin)) > 15;
        v = (d[7] == x[7]) && (r9[7] != d[7]);
        r = r9[7:0];
        m = 6'h2f;
      end
      4'h2, 4'h3, 4'h4, 4'h5: begin
        r9 = {1'b0, d} - {1'b0, x} - {8'h00, cin};
        c = r9[8];
        h = int'(d[3:0]) < (int'(x[3:0]) + int'(cin));
        v = (d[7] != x[7]) && (r9[7] != d[7]);
        r = r9[7:0];
        m = 6'h2f;
      end
      4'h6, 4'h7: r = d & x;
      4'h8, 4'h9: r = d | x;
      4'ha: r = d;
      4'hb: begin
        r = d + 8'h01;
        v = (r == 8'h80);
      end
      default: begin
        w = (op == 4'hc) ? {1'b0, hi, d} + {9'h000, k} : {1'b0, hi, d} - {9'h000, k};
        c = w[16];
        v = (op == 4'hc) ? (!hi[7] && w[15]) : (hi[7] && !w[15]);
        r = w[7:0];
        rh = w[15:8];
        m = 6'h1f;
      end
    endcase
    n = (op >= 4'hc) ? w[15] : r[7];
    z = (op >= 4'hc) ? (w[15:0] == 16'h0000) : (r == 8'h00);
    nf = {h, n ^ v, v, n, z, c};
    return {(nf & m) | (fl & ~m), rh, r};
  endfunction : model

  // ----------------------------------------------------------------
  // One operation with loaded operands, then read back
  // ----------------------------------------------------------------
  task automatic run_op(input int op, input int i);
    logic [31:0] rnd;
    logic [31:0] rd;
    logic [21:0] e;
    rnd = $random(seed);
    if (i == 0) rnd = 32'hff01_01ff;
    if (i == 1) rnd = 32'h7f7f_7f7f;
    rd = $random(seed);
    e = model(op[3:0], rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24], rd[5:0]);
    host.write_reg(OFF_DEST, {24'h0, rnd[7:0]});
    host.write_reg(OFF_SRC, {24'h0, rnd[15:8]});
    host.write_reg(OFF_IMM, {24'h0, rnd[23:16]});
    host.write_reg(OFF_PAIR_HI, {24'h0, rnd[31:24]});
    host.write_reg(OFF_FLAGS, {26'h0, rd[5:0]});
    host.write_reg(OFF_CMD, {28'h0, op[3:0]});
    host.read_reg(OFF_DEST, rd);
    check(rd, {24'h0, e[7:0]});
    host.read_reg(OFF_PAIR_HI, rd);
    check(rd, {24'h0, e[15:8]});
    host.read_reg(OFF_FLAGS, rd);
    check(rd, {26'h0, e[21:16]});
    host.read_reg(OFF_CMD, rd);
    check(rd, {28'h0, op[3:0]});
    check({31'h0, hresp}, 32'h0);
  endtask : run_op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    hresetn = 1'b0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    seed = 32'h39e8;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Every register clears on reset, the unused slot included
    for (int a = 0; a < 8; a++) begin
      host.read_reg(a * 4, rd);
      check(rd, 32'h0);
    end
    host.write_reg(32'h0000_001c, 32'hffff_ffff);
    host.read_reg(32'h0000_001c, rd);
    check(rd, 32'h0);
    for (int op = 0; op < 14; op++) begin
      for (int i = 0; i < 8; i++) begin
        run_op(op, i);
      end
    end
    // An unused opcode leaves the operands and flags alone
    host.write_reg(OFF_DEST, 32'h0000_005a);
    host.write_reg(OFF_FLAGS, 32'h0000_0015);
    host.write_reg(OFF_CMD, 32'h0000_000e);
    host.read_reg(OFF_DEST, rd);
    check(rd, 32'h0000_005a);
    host.read_reg(OFF_FLAGS, rd);
    check(rd, 32'h0000_0015);
    host.read_reg(OFF_STATUS, rd);
    check(rd, 32'h0);
    finish_test();
  end
endmodule : arith_logic_unit_tb
